// *** capture_edge_detect.v ***
// Input capture edge detector for one channel pin
`timescale 1ns/1ns
`include "pwm_timer_map.vh"
module capture_edge_detect (
  input wire aclk,
  input wire aresetn,
  input wire pin_in,
  input wire [1:0] edge_sel,
  output wire edge_hit
);
  reg prev_reg;
  wire rise;
  wire fall;

  assign rise = pin_in & ~prev_reg;
  assign fall = ~pin_in & prev_reg;
  // Rising, falling or any edge by selection
  assign edge_hit = (edge_sel == `ELS_TOGGLE) ? rise :
    (edge_sel == `ELS_CLEAR) ? fall :
    (edge_sel == `ELS_SET) ? (rise | fall) : 1'b0;

  // Previous pin level
  always @(posedge aclk) begin
    if (!aresetn) begin
      prev_reg <= 1'b0;
    end else begin
      prev_reg <= pin_in;
    end
  end
endmodule // capture_edge_detect

// *** count_clock_select.v ***
// Counter clock source: bus clock prescaler or synchronised external clock
`timescale 1ns/1ns
`include "pwm_timer_map.vh"
module count_clock_select #(
  parameter DIV_W = 6
) (
  input wire aclk,
  input wire aresetn,
  input wire run,
  input wire clear,
  input wire [2:0] prescale_select,
  input wire external_count_clock,
  output wire tick
);
  reg [DIV_W-1:0] div_reg;
  reg ext_s1_reg;
  reg ext_s2_reg;
  reg ext_s3_reg;
  wire [DIV_W-1:0] div_mask;
  wire ext_rise;

  // Low ones select the division ratio
  assign div_mask = ~({DIV_W{1'b1}} << prescale_select);
  assign ext_rise = ext_s2_reg & ~ext_s3_reg;
  assign tick = run & ((prescale_select == `PS_EXTERNAL) ? ext_rise :
    ((div_reg & div_mask) == div_mask));

  // Prescaler counts only while the counter runs
  always @(posedge aclk) begin
    if (!aresetn || clear) begin
      div_reg <= {DIV_W{1'b0}};
    end else if (run) begin
      div_reg <= div_reg + {{(DIV_W-1){1'b0}}, 1'b1};
    end
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      ext_s1_reg <= 1'b0;
      ext_s2_reg <= 1'b0;
      ext_s3_reg <= 1'b0;
    end else begin
      ext_s1_reg <= external_count_clock;
      ext_s2_reg <= ext_s1_reg;
      ext_s3_reg <= ext_s2_reg;
    end
  end
endmodule // count_clock_select

// *** pin_load_model.sv ***
// Far-side model: pulled-up channel pins and an external count clock source
`timescale 1ns/1ns
module pin_load_model #(
  parameter int HALF_NS = 128
) (
  input wire ext_run,
  input wire chan0_pin_out,
  input wire chan0_pin_oe,
  input wire chan1_pin_out,
  input wire chan1_pin_oe,
  output wire chan0_pin_in,
  output wire chan1_pin_in,
  output logic external_count_clock
);
  assign chan0_pin_in = chan0_pin_oe ? chan0_pin_out : 1'b1;
  assign chan1_pin_in = chan1_pin_oe ? chan1_pin_out : 1'b1;
  // below 4 MHz, still when idle
  initial begin
    external_count_clock = 1'b0;
    #3;
    forever begin
      #(HALF_NS);
      external_count_clock = ext_run ? ~external_count_clock : 1'b0;
    end
  end
endmodule // pin_load_model

// *** pwm_timer_map.vh ***
// Register map, field positions and reset values of the two-channel PWM timer
`ifndef PWM_TIMER_MAP_VH
`define PWM_TIMER_MAP_VH

// Register byte offsets
`define OFS_MAIN_CTL 5'h00
`define OFS_COUNT 5'h04
`define OFS_MODULO 5'h08
`define OFS_CH0_CTL 5'h0C
`define OFS_CH0_CMP 5'h10
`define OFS_CH1_CTL 5'h14
`define OFS_CH1_CMP 5'h18
`define OFS_SYS_CTL 5'h1C

// Main control fields
`define MC_FLAG 7
`define MC_IE 6
`define MC_HALT 5
`define MC_RST 4
`define MC_PS_HI 2
`define MC_PS_LO 0

// Channel control fields
`define CC_FLAG 7
`define CC_IE 6
`define CC_MSB 5
`define CC_MSA 4
`define CC_ELS_HI 3
`define CC_ELS_LO 2
`define CC_TOV 1
`define CC_MAX 0

// System control field
`define SC_BREAK_CLEAR_ENABLE 0

// Reset values and codes
`define RST_MODULO 16'hFFFF
`define RST_COUNT 16'h0000
`define RST_CMP 16'h0000
`define RST_CH_CTL 7'h00
`define RST_PS 3'h0
`define PS_EXTERNAL 3'h7
`define ELS_NONE 2'h0
`define ELS_TOGGLE 2'h1
`define ELS_CLEAR 2'h2
`define ELS_SET 2'h3
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// *** pwm_timer_sva.sv ***
// Checker on bus handshakes, low-power modes and request pins of the PWM timer
`timescale 1ns/1ns
`include "pwm_timer_map.vh"
module pwm_timer_sva (
  input wire aclk,
  input wire aresetn,
  input wire s_axi_awvalid,
  input wire s_axi_awready,
  input wire s_axi_wvalid,
  input wire s_axi_wready,
  input wire [1:0] s_axi_bresp,
  input wire s_axi_bvalid,
  input wire s_axi_bready,
  input wire s_axi_arvalid,
  input wire s_axi_arready,
  input wire [31:0] s_axi_rdata,
  input wire [1:0] s_axi_rresp,
  input wire s_axi_rvalid,
  input wire s_axi_rready,
  input wire wait_mode,
  input wire stop_mode,
  input wire break_state,
  input wire chan0_pin_out,
  input wire overflow_irq,
  input wire chan0_irq,
  input wire chan1_irq,
  input wire wake_request
);
  // One clock domain, reset disables all
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  // Counter frozen by stop or break
  wire frz = stop_mode | break_state;

  chk_wake_or: assert property (
    wake_request == (overflow_irq | chan0_irq | chan1_irq))
    else $error("wake request differs from request OR");
  chk_wait_wresp: assert property (
    $rose(s_axi_bvalid) && $past(wait_mode) |-> s_axi_bresp == `RESP_SLVERR)
    else $error("write in wait mode not refused");
  chk_wait_rresp: assert property (
    $rose(s_axi_rvalid) && $past(wait_mode) |-> s_axi_rresp == `RESP_SLVERR)
    else $error("read in wait mode not refused");
  chk_b_hold: assert property (
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped early");
  chk_r_hold: assert property (
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped early");
  chk_w_latency: assert property (
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
    else $error("write response late");
  chk_r_latency: assert property (
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read response late");
  chk_halt_freeze: assert property (
    frz && $past(frz) && $past(frz, 2) && !s_axi_bvalid && !$past(s_axi_bvalid)
    |-> $stable(chan0_pin_out) && $stable(overflow_irq))
    else $error("timer moved while frozen");
endmodule // pwm_timer_sva

bind two_channel_timer_pwm pwm_timer_sva chk_u (
  .aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
  .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready,
  .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .wait_mode, .stop_mode,
  .break_state, .chan0_pin_out, .overflow_irq, .chan0_irq, .chan1_irq, .wake_request
);

// *** testbench.sv ***
// Self-checking bench for the two-channel PWM timer
`timescale 1ns/1ns
`include "pwm_timer_map.vh"
module testbench;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [4:0] s_axi_awaddr = 5'h00;
  logic [4:0] s_axi_araddr = 5'h00;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, ext_run = 1'b0;
  logic wait_mode = 1'b0, stop_mode = 1'b0, break_state = 1'b0;
  wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire [1:0] s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata;
  wire external_count_clock, chan0_pin_in, chan1_pin_in, chan0_pin_out, chan0_pin_oe;
  wire chan1_pin_out, chan1_pin_oe, overflow_irq, chan0_irq, chan1_irq, wake_request;
  logic [31:0] rd, c;
  int n_mismatch = 0, checks = 0, hi, per;

  // Bus clock 125 MHz
  always #4 aclk = ~aclk;

  // Device and far-side load
  two_channel_timer_pwm dut_u (
    .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .wait_mode, .stop_mode, .break_state, .external_count_clock,
    .chan0_pin_in, .chan0_pin_out, .chan0_pin_oe, .chan1_pin_in, .chan1_pin_out,
    .chan1_pin_oe, .overflow_irq, .chan0_irq, .chan1_irq, .wake_request
  );
  pin_load_model load_u (
    .ext_run, .chan0_pin_out, .chan0_pin_oe, .chan1_pin_out, .chan1_pin_oe,
    .chan0_pin_in, .chan1_pin_in, .external_count_clock
  );

  // Verdict and end of run
  task automatic finish_test();
    $display("mismatches %0d checks %0d", n_mismatch, checks);
    if (n_mismatch == 0 && checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  task automatic bound(input int n, input int lim);
    if (n >= lim) begin
      $display("CHECK FAILED wait bound expected below %0d seen %0d", lim, n);
      n_mismatch++;
      finish_test();
    end
  endtask

  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // Bus write, address and data offered together
  task automatic wr(input logic [4:0] a, input logic [31:0] d, input logic [1:0] er);
    int n;
    logic aw, w;
    n = 0;
    aw = 1'b0;
    w = 1'b0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!(aw && w) && n < 50) begin
      @(posedge aclk);
      n++;
      if (!aw && s_axi_awready === 1'b1) begin
        aw = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (!w && s_axi_wready === 1'b1) begin
        w = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
    end
    while (s_axi_bvalid !== 1'b1 && n < 50) begin
      @(posedge aclk);
      n++;
    end
    bound(n, 50);
    s_axi_bready <= 1'b0;
    check("bresp", s_axi_bresp, er);
  endtask

  // Bus read into rd
  task automatic rd_reg(input logic [4:0] a, input logic [1:0] er);
    int n;
    logic ar;
    n = 0;
    ar = 1'b0;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    // Hold the address until the edge that takes it
    while (!ar && n < 50) begin
      @(posedge aclk);
      n++;
      if (s_axi_arready === 1'b1) begin
        ar = 1'b1;
        s_axi_arvalid <= 1'b0;
      end
    end
    while (s_axi_rvalid !== 1'b1 && n < 50) begin
      @(posedge aclk);
      n++;
    end
    bound(n, 50);
    rd = s_axi_rdata;
    s_axi_rready <= 1'b0;
    check("rresp", s_axi_rresp, er);
  endtask

  task automatic rck(input string nm, input logic [4:0] a, input logic [31:0] exp);
    rd_reg(a, `RESP_OKAY);
    check(nm, rd, exp);
  endtask

  // Pin watching on the falling edge
  task automatic pin_wait(input logic v);
    int n;
    n = 0;
    while (chan0_pin_out !== v && n < 5000) begin
      @(negedge aclk);
      n++;
    end
    bound(n, 5000);
  endtask

  task automatic measure();
    repeat (24) @(negedge aclk);
    pin_wait(1'b0);
    pin_wait(1'b1);
    hi = 0;
    while (chan0_pin_out === 1'b1 && hi < 5000) begin
      @(negedge aclk);
      hi++;
    end
    per = hi;
    while (chan0_pin_out === 1'b0 && per < 10000) begin
      @(negedge aclk);
      per++;
    end
    bound(per, 10000);
  endtask

  task automatic flat(input logic v);
    repeat (24) @(negedge aclk);
    for (int i = 0; i < 16; i++) begin
      @(negedge aclk);
      check("flat pin", chan0_pin_out, v);
    end
  endtask

  // Main sequence
  initial begin
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    rck("main reset", `OFS_MAIN_CTL, 32'h20);
    rck("modulo reset", `OFS_MODULO, 32'hFFFF);
    rck("sys reset", `OFS_SYS_CTL, 32'h0);
    rd_reg(5'h02, `RESP_SLVERR);
    wr(`OFS_COUNT, 32'h1, `RESP_SLVERR);
    wr(`OFS_MAIN_CTL, 32'h30, `RESP_OKAY);
    wr(`OFS_MODULO, 32'h7, `RESP_OKAY);
    wr(`OFS_CH0_CMP, 32'h2, `RESP_OKAY);
    wr(`OFS_CH0_CTL, 32'h1A, `RESP_OKAY);
    for (int ps = 0; ps < 7; ps++) begin
      wr(`OFS_MAIN_CTL, ps, `RESP_OKAY);
      measure();
      check("high time", hi, 3 << ps);
      check("period", per, 8 << ps);
    end
    wr(`OFS_CH0_CTL, 32'h1E, `RESP_OKAY);
    wr(`OFS_MAIN_CTL, 32'h0, `RESP_OKAY);
    measure();
    check("set polarity high", hi, 5);
    wr(`OFS_CH0_CTL, 32'h1A, `RESP_OKAY);
    wr(`OFS_CH0_CMP, 32'h4, `RESP_OKAY);
    measure();
    check("unbuffered high", hi, 5);
    wr(`OFS_CH0_CTL, 32'h18, `RESP_OKAY);
    flat(1'b0);
    wr(`OFS_CH0_CTL, 32'h1B, `RESP_OKAY);
    flat(1'b1);
    wr(`OFS_CH0_CTL, 32'h1A, `RESP_OKAY);
    check("ovf irq off", overflow_irq, 1'b0);
    wr(`OFS_MAIN_CTL, 32'h40, `RESP_OKAY);
    repeat (20) @(posedge aclk);
    check("ovf irq", overflow_irq, 1'b1);
    check("ch0 irq off", chan0_irq, 1'b0);
    rck("ch0 flag", `OFS_CH0_CTL, 32'h9A);
    wr(`OFS_CH0_CTL, 32'h5A, `RESP_OKAY);
    repeat (20) @(posedge aclk);
    check("ch0 irq on", chan0_irq, 1'b1);
    check("wake", wake_request, 1'b1);
    wr(`OFS_MAIN_CTL, 32'h60, `RESP_OKAY);
    rck("unarmed clear", `OFS_MAIN_CTL, 32'hE0);
    wr(`OFS_MAIN_CTL, 32'h60, `RESP_OKAY);
    rck("armed clear", `OFS_MAIN_CTL, 32'h60);
    check("ovf irq cleared", overflow_irq, 1'b0);
    wr(`OFS_MAIN_CTL, 32'h40, `RESP_OKAY);
    repeat (16) @(posedge aclk);
    break_state <= 1'b1;
    rd_reg(`OFS_COUNT, `RESP_OKAY);
    c = rd;
    rd_reg(`OFS_COUNT, `RESP_OKAY);
    check("break count", rd, c);
    rck("break flag", `OFS_MAIN_CTL, 32'hC0);
    wr(`OFS_MAIN_CTL, 32'h40, `RESP_OKAY);
    rck("protected flag", `OFS_MAIN_CTL, 32'hC0);
    wr(`OFS_SYS_CTL, 32'h1, `RESP_OKAY);
    rck("arm in break", `OFS_MAIN_CTL, 32'hC0);
    wr(`OFS_MAIN_CTL, 32'h40, `RESP_OKAY);
    rck("break clear", `OFS_MAIN_CTL, 32'h40);
    @(posedge aclk);
    break_state <= 1'b0;
    repeat (16) @(posedge aclk);
    stop_mode <= 1'b1;
    rd_reg(`OFS_COUNT, `RESP_OKAY);
    c = rd;
    repeat (8) @(posedge aclk);
    rd_reg(`OFS_COUNT, `RESP_OKAY);
    check("stop count", rd, c);
    rck("stop keeps", `OFS_MODULO, 32'h7);
    @(posedge aclk);
    stop_mode <= 1'b0;
    wait_mode <= 1'b1;
    wr(`OFS_MODULO, 32'h3, `RESP_SLVERR);
    rd_reg(`OFS_MODULO, `RESP_SLVERR);
    measure();
    check("wait period", per, 8);
    @(posedge aclk);
    wait_mode <= 1'b0;
    rck("wait no write", `OFS_MODULO, 32'h7);
    wr(`OFS_CH1_CTL, 32'h5A, `RESP_OKAY);
    repeat (20) @(posedge aclk);
    check("ch1 oe", chan1_pin_oe, 1'b1);
    wr(`OFS_CH0_CTL, 32'h3A, `RESP_OKAY);
    repeat (4) @(posedge aclk);
    check("ch1 released", chan1_pin_oe, 1'b0);
    check("ch1 irq off", chan1_irq, 1'b0);
    check("ch0 oe linked", chan0_pin_oe, 1'b1);
    measure();
    check("linked ch0", hi, 5);
    wr(`OFS_CH1_CMP, 32'h1, `RESP_OKAY);
    measure();
    check("linked ch1", hi, 2);
    wr(`OFS_CH0_CMP, 32'h5, `RESP_OKAY);
    measure();
    check("linked back", hi, 6);
    wr(`OFS_CH0_CTL, 32'h1A, `RESP_OKAY);
    wr(`OFS_CH0_CMP, 32'h2, `RESP_OKAY);
    @(posedge aclk);
    ext_run <= 1'b1;
    wr(`OFS_MAIN_CTL, {29'h0, `PS_EXTERNAL}, `RESP_OKAY);
    measure();
    check("ext period", per, 256);
    check("ext high", hi, 96);
    finish_test();
  end
endmodule // testbench

// *** two_channel_timer_pwm.v ***
// Two-channel 16-bit timer with PWM generation and AXI4-Lite registers
`timescale 1ns/1ns
`include "pwm_timer_map.vh"
module two_channel_timer_pwm #(
  parameter ADDR_W = 5
) (
  input wire aclk,
  input wire aresetn,
  input wire [ADDR_W-1:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  output wire [1:0] s_axi_bresp,
  output wire s_axi_bvalid,
  input wire s_axi_bready,
  input wire [ADDR_W-1:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  output wire [31:0] s_axi_rdata,
  output wire [1:0] s_axi_rresp,
  output wire s_axi_rvalid,
  input wire s_axi_rready,
  input wire wait_mode,
  input wire stop_mode,
  input wire break_state,
  input wire external_count_clock,
  input wire chan0_pin_in,
  output wire chan0_pin_out,
  output wire chan0_pin_oe,
  input wire chan1_pin_in,
  output wire chan1_pin_out,
  output wire chan1_pin_oe,
  output wire overflow_irq,
  output wire chan0_irq,
  output wire chan1_irq,
  output wire wake_request
);
  // Bus side state
  reg aw_full_reg;
  reg w_full_reg;
  reg [ADDR_W-1:0] aw_addr_reg;
  reg [31:0] wdata_reg;
  reg [3:0] wstrb_reg;
  reg bvalid_reg;
  reg [1:0] bresp_reg;
  reg rvalid_reg;
  reg [1:0] rresp_reg;
  reg [31:0] rdata_reg;
  reg [31:0] rd_mux;
  reg rd_hit;

  // Timer state
  reg [15:0] cnt_reg;
  reg [15:0] mod_reg;
  reg [2:0] prescale_select_reg;
  reg counter_halt_bit_reg;
  reg overflow_irq_enable_reg;
  reg overflow_flag_reg;
  reg ovf_arm_reg;
  reg break_clear_enable_reg;
  reg act_sel_reg;
  reg last_wr_reg;

  wire ar_take;
  wire wr_go;
  wire wr_ok;
  wire rd_ok;
  wire wr_mapped;
  wire protect;
  wire run;
  wire tick;
  wire cnt_clear;
  wire ovf_evt;
  wire linked;
  wire [15:0] cnt_next;
  wire main_wr;
  wire main_rd;
  wire [31:0] cmp_all;
  wire [15:0] ctl_all;
  wire [1:0] flag_all;
  wire [1:0] ie_all;
  wire [1:0] pin_in_w;
  wire [1:0] pin_out_w;
  wire [1:0] pin_oe_w;

  // Byte-lane merge of a 16-bit register
  function [15:0] merge16;
    input [15:0] old;
    input [31:0] data;
    input [3:0] strb;
    begin
      merge16 = {strb[1] ? data[15:8] : old[15:8], strb[0] ? data[7:0] : old[7:0]};
    end
  endfunction

  // Handshakes
  assign s_axi_awready = ~aw_full_reg & ~bvalid_reg;
  assign s_axi_wready = ~w_full_reg & ~bvalid_reg;
  assign s_axi_arready = ~rvalid_reg;
  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp = bresp_reg;
  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rresp = rresp_reg;
  assign s_axi_rdata = rdata_reg;
  assign ar_take = s_axi_arvalid & ~rvalid_reg;
  assign wr_go = aw_full_reg & w_full_reg & ~bvalid_reg;
  assign wr_mapped = (aw_addr_reg[1:0] == 2'b00) && (aw_addr_reg <= `OFS_SYS_CTL)
    && (aw_addr_reg != `OFS_COUNT);
  assign wr_ok = wr_go & wr_mapped & ~wait_mode;
  assign rd_ok = ar_take & ~wait_mode;
  assign protect = break_state & ~break_clear_enable_reg;

  // Write address and data taken in either order
  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_full_reg <= 1'b0;
      w_full_reg <= 1'b0;
      aw_addr_reg <= {ADDR_W{1'b0}};
      wdata_reg <= 32'h00000000;
      wstrb_reg <= 4'h0;
      bvalid_reg <= 1'b0;
      bresp_reg <= `RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_full_reg <= 1'b1;
        aw_addr_reg <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_full_reg <= 1'b1;
        wdata_reg <= s_axi_wdata;
        wstrb_reg <= s_axi_wstrb;
      end
      if (wr_go) begin
        aw_full_reg <= 1'b0;
        w_full_reg <= 1'b0;
        bvalid_reg <= 1'b1;
        bresp_reg <= (wr_mapped && !wait_mode) ? `RESP_OKAY : `RESP_SLVERR;
      end else if (bvalid_reg && s_axi_bready) begin
        bvalid_reg <= 1'b0;
      end
    end
  end

  // Read data selection
  always @* begin
    rd_mux = 32'h00000000;
    rd_hit = 1'b1;
    if (s_axi_araddr == `OFS_MAIN_CTL) begin
      rd_mux[7:0] = {overflow_flag_reg, overflow_irq_enable_reg, counter_halt_bit_reg,
        2'b00, prescale_select_reg};
    end else if (s_axi_araddr == `OFS_COUNT) begin
      rd_mux[15:0] = cnt_reg;
    end else if (s_axi_araddr == `OFS_MODULO) begin
      rd_mux[15:0] = mod_reg;
    end else if (s_axi_araddr == `OFS_CH0_CTL) begin
      rd_mux[7:0] = ctl_all[7:0];
    end else if (s_axi_araddr == `OFS_CH0_CMP) begin
      rd_mux[15:0] = cmp_all[15:0];
    end else if (s_axi_araddr == `OFS_CH1_CTL) begin
      rd_mux[7:0] = ctl_all[15:8];
    end else if (s_axi_araddr == `OFS_CH1_CMP) begin
      rd_mux[15:0] = cmp_all[31:16];
    end else if (s_axi_araddr == `OFS_SYS_CTL) begin
      rd_mux[`SC_BREAK_CLEAR_ENABLE] = break_clear_enable_reg;
    end else begin
      rd_hit = 1'b0;
    end
  end

  // Read answer one cycle after address
  always @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_reg <= 1'b0;
      rresp_reg <= `RESP_OKAY;
      rdata_reg <= 32'h00000000;
    end else if (ar_take) begin
      rvalid_reg <= 1'b1;
      rresp_reg <= (rd_hit && !wait_mode) ? `RESP_OKAY : `RESP_SLVERR;
      rdata_reg <= (rd_hit && !wait_mode) ? rd_mux : 32'h00000000;
    end else if (rvalid_reg && s_axi_rready) begin
      rvalid_reg <= 1'b0;
    end
  end

  // Main control decode
  assign main_wr = wr_ok && (aw_addr_reg == `OFS_MAIN_CTL) && wstrb_reg[0];
  assign main_rd = rd_ok && (s_axi_araddr == `OFS_MAIN_CTL);
  assign cnt_clear = main_wr & wdata_reg[`MC_RST];
  assign run = ~counter_halt_bit_reg & ~stop_mode & ~break_state;

  count_clock_select u_clk_sel (
    .aclk(aclk),
    .aresetn(aresetn),
    .run(run),
    .clear(cnt_clear),
    .prescale_select(prescale_select_reg),
    .external_count_clock(external_count_clock),
    .tick(tick)
  );

  assign cnt_next = (cnt_reg == mod_reg) ? 16'h0000 : cnt_reg + 16'h0001;
  assign ovf_evt = tick & (cnt_next == mod_reg);

  // Counter, modulo and main control bits
  always @(posedge aclk) begin
    if (!aresetn) begin
      cnt_reg <= `RST_COUNT;
      mod_reg <= `RST_MODULO;
      prescale_select_reg <= `RST_PS;
      counter_halt_bit_reg <= 1'b1;
      overflow_irq_enable_reg <= 1'b0;
      break_clear_enable_reg <= 1'b0;
    end else begin
      if (cnt_clear) begin
        cnt_reg <= `RST_COUNT;
      end else if (tick) begin
        cnt_reg <= cnt_next;
      end
      if (wr_ok && aw_addr_reg == `OFS_MODULO) begin
        mod_reg <= merge16(mod_reg, wdata_reg, wstrb_reg);
      end
      if (main_wr) begin
        overflow_irq_enable_reg <= wdata_reg[`MC_IE];
        counter_halt_bit_reg <= wdata_reg[`MC_HALT];
        prescale_select_reg <= wdata_reg[`MC_PS_HI:`MC_PS_LO];
      end
      if (wr_ok && aw_addr_reg == `OFS_SYS_CTL && wstrb_reg[0]) begin
        break_clear_enable_reg <= wdata_reg[`SC_BREAK_CLEAR_ENABLE];
      end
    end
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      overflow_flag_reg <= 1'b0;
      ovf_arm_reg <= 1'b0;
    end else if (ovf_evt) begin
      overflow_flag_reg <= 1'b1;
      ovf_arm_reg <= 1'b0;
    end else if (main_rd && overflow_flag_reg && !protect) begin
      ovf_arm_reg <= 1'b1;
    end else if (main_wr && !wdata_reg[`MC_FLAG] && ovf_arm_reg && !protect) begin
      overflow_flag_reg <= 1'b0;
      ovf_arm_reg <= 1'b0;
    end
  end

  assign linked = ctl_all[`CC_MSB];

  always @(posedge aclk) begin
    if (!aresetn || !linked) begin
      act_sel_reg <= 1'b0;
      last_wr_reg <= 1'b0;
    end else begin
      if (wr_ok && aw_addr_reg == `OFS_CH0_CMP) begin
        last_wr_reg <= 1'b0;
      end else if (wr_ok && aw_addr_reg == `OFS_CH1_CMP) begin
        last_wr_reg <= 1'b1;
      end
      if (ovf_evt) begin
        act_sel_reg <= last_wr_reg;
      end
    end
  end

  assign pin_in_w = {chan1_pin_in, chan0_pin_in};

  genvar i;
  generate
    for (i = 0; i < 2; i = i + 1) begin : g_chan
      localparam [ADDR_W-1:0] CTL_OFS = (i == 0) ? `OFS_CH0_CTL : `OFS_CH1_CTL;
      localparam [ADDR_W-1:0] CMP_OFS = (i == 0) ? `OFS_CH0_CMP : `OFS_CH1_CMP;
      reg [6:0] ctl_reg;
      reg [15:0] cmp_reg;
      reg flag_reg;
      reg arm_reg;
      reg out_reg;
      wire ign;
      wire msb;
      wire [1:0] els;
      wire oc;
      wire ic;
      wire [15:0] cmp_eff;
      wire cmp_evt;
      wire edge_hit;
      wire cap_evt;
      wire evt;
      wire ctl_wr;
      wire ctl_rd;
      wire pulse_lvl;

      assign ign = (i == 1) && linked;
      assign msb = (i == 0) ? ctl_reg[`CC_MSB] : 1'b0;
      assign els = ctl_reg[`CC_ELS_HI:`CC_ELS_LO];
      assign oc = ~ign & (msb | ctl_reg[`CC_MSA]) & (els != `ELS_NONE);
      assign ic = ~ign & ~msb & ~ctl_reg[`CC_MSA] & (els != `ELS_NONE);
      assign cmp_eff = ((i == 0) && linked && act_sel_reg) ? cmp_all[31:16] : cmp_reg;
      assign cmp_evt = oc & tick & (cnt_next == cmp_eff);
      assign cap_evt = ic & edge_hit & run;
      assign evt = cmp_evt | cap_evt;
      assign ctl_wr = wr_ok && (aw_addr_reg == CTL_OFS) && wstrb_reg[0];
      assign ctl_rd = rd_ok && (s_axi_araddr == CTL_OFS);
      // pulse is complement of compare action
      assign pulse_lvl = (els == `ELS_SET) ? 1'b0 : 1'b1;

      capture_edge_detect u_edge (
        .aclk(aclk),
        .aresetn(aresetn),
        .pin_in(pin_in_w[i]),
        .edge_sel(els),
        .edge_hit(edge_hit)
      );

      // Control and compare registers
      always @(posedge aclk) begin
        if (!aresetn) begin
          ctl_reg <= `RST_CH_CTL;
          cmp_reg <= `RST_CMP;
        end else begin
          if (ctl_wr) begin
            ctl_reg <= wdata_reg[6:0];
          end
          if (cap_evt) begin
            cmp_reg <= cnt_reg;
          end else if (wr_ok && aw_addr_reg == CMP_OFS) begin
            cmp_reg <= merge16(cmp_reg, wdata_reg, wstrb_reg);
          end
        end
      end

      always @(posedge aclk) begin
        if (!aresetn) begin
          flag_reg <= 1'b0;
          arm_reg <= 1'b0;
        end else if (evt) begin
          flag_reg <= 1'b1;
          arm_reg <= 1'b0;
        end else if (ctl_rd && flag_reg && !protect) begin
          arm_reg <= 1'b1;
        end else if (ctl_wr && !wdata_reg[`CC_FLAG] && arm_reg && !protect) begin
          flag_reg <= 1'b0;
          arm_reg <= 1'b0;
        end
      end

      // Output level: preset, 100%, overflow toggle, compare action
      always @(posedge aclk) begin
        if (!aresetn) begin
          out_reg <= 1'b1;
        end else if (els == `ELS_NONE) begin
          out_reg <= ~ctl_reg[`CC_MSA];
        end else if (oc) begin
          if (ctl_reg[`CC_TOV] && ctl_reg[`CC_MAX]) begin
            out_reg <= pulse_lvl;
          end else if (ovf_evt && ctl_reg[`CC_TOV]) begin
            out_reg <= ~out_reg;
          end else if (cmp_evt) begin
            out_reg <= (els == `ELS_TOGGLE) ? ~out_reg : (els == `ELS_SET);
          end
        end
      end

      assign ctl_all[i*8+7:i*8] = {flag_reg, ctl_reg[`CC_IE], msb, ctl_reg[4:0]};
      assign cmp_all[i*16+15:i*16] = cmp_reg;
      assign flag_all[i] = flag_reg;
      assign ie_all[i] = ctl_reg[`CC_IE] & ~ign;
      assign pin_out_w[i] = out_reg;
      assign pin_oe_w[i] = oc;
    end
  endgenerate

  assign chan0_pin_out = pin_out_w[0];
  assign chan0_pin_oe = pin_oe_w[0];
  assign chan1_pin_out = pin_out_w[1];
  assign chan1_pin_oe = pin_oe_w[1];
  assign overflow_irq = overflow_flag_reg & overflow_irq_enable_reg;
  assign chan0_irq = flag_all[0] & ie_all[0];
  assign chan1_irq = flag_all[1] & ie_all[1];
  assign wake_request = overflow_irq | chan0_irq | chan1_irq;
endmodule // two_channel_timer_pwm
